// ==== design/sensor_adc_register_bank.sv ====
// register bank of a sensor acquisition device: result formatting, bias
// selections, oscillator enable, two multi-function pads, configuration.
// assumes a host-side serial bridge presenting a one-cycle strobe port and
// a modulator core delivering a wide signed raw sum with a valid pulse.
//
// Operation
// [RQ1] result is 16-bit two's complement
// [RQ2] out-of-range result clamps to extreme code
// [RQ3] low bits forced to 1-then-zeros below 16 bits
// [RQ4] converter bias codes quarter, half, full
// [RQ5] amplifier bias uses same codes independently
// [RQ6] host may disable stages when idle
// [RQ7] unused bits ignore writes
// [RQ8] reset loads every field default
// [RQ9] oscillator enable bit 0, resets one
// [RQ10] pad direction bits 5 and 4
// [RQ11] pad one driven unless reference input
// [RQ12] pad zero driven unless reference output
// [RQ13] input register shows live pad levels
// [RQ14] result low byte then high byte
// [RQ15] decode six configuration and mode registers
// [RQ16] bit 7 of first config starts conversion
// [RQ17] mode bits enable reference pad functions
// [RQ18] both result bytes from one conversion
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module sensor_adc_register_bank
(
   input  wire logic                          clk,
   input  wire logic                          srst,
   input  wire adc_regs_pkg::reg_req_type     req,
   output logic [adc_regs_pkg::DATA_W-1:0]    rdata,
   input  wire adc_regs_pkg::raw_result_type  raw,
   input  wire logic                          conv_busy,
   output logic                               conv_start,
   output logic                               osc_enable,
   output logic [1:0]                         converter_bias_select,
   output logic [1:0]                         amplifier_bias_select,
   output logic [3:0]                         stage_enable,
   output logic                               reference_out_enable,
   output logic                               ext_reference_in_enable,
   input  wire logic                          pad0_in,
   input  wire logic                          pad1_in,
   output logic                               pad0_out,
   output logic                               pad0_oe,
   output logic                               pad1_out,
   output logic                               pad1_oe
);

   logic [7:0]  osc_r;
   logic [7:0]  pad_r;
   logic [7:0]  cfg_r [6];
   logic [7:0]  mode_r;
   logic [15:0] result_r;
   logic [15:0] result_nxt;
   logic [1:0]  pad_meta_r;
   logic [1:0]  pad_live_r;
   logic        start_r;
   logic [7:0]  rdata_r;
   logic [7:0]  rdata_nxt;
   logic [2:0]  osr_sel;
   logic [1:0]  nelc_sel;
   logic [4:0]  res_bits;
   logic [15:0] forced_one;
   logic [15:0] keep_mask;
   logic [15:0] sat_code;

   localparam logic [7:0] CFG_MASK [6] = '{adc_regs_pkg::CFG_A_MASK,
      adc_regs_pkg::CFG_B_MASK, adc_regs_pkg::CFG_C_MASK,
      adc_regs_pkg::CFG_D_MASK, adc_regs_pkg::CFG_E_MASK,
      adc_regs_pkg::CFG_F_MASK};
   localparam logic [7:0] CFG_RST [6] = '{adc_regs_pkg::CFG_A_RST,
      adc_regs_pkg::CFG_B_RST, adc_regs_pkg::CFG_C_RST,
      adc_regs_pkg::CFG_D_RST, adc_regs_pkg::CFG_E_RST,
      adc_regs_pkg::CFG_F_RST};

   wire logic wr_hit_cfg = req.wr
      && req.addr >= adc_regs_pkg::CFG_A_ADDR
      && req.addr <= adc_regs_pkg::CFG_F_ADDR;
   wire logic [2:0] cfg_idx = 3'(req.addr - adc_regs_pkg::CFG_A_ADDR);

   // oscillator control, masked so upper bits stay zero
   always_ff @(posedge clk)
   begin
      if (srst)
         osc_r <= adc_regs_pkg::OSC_CONTROL_RST;                  // [RQ8]
      else if (req.wr && req.addr == adc_regs_pkg::OSC_CONTROL_ADDR)
         osc_r <= req.wdata & adc_regs_pkg::OSC_CONTROL_MASK;     // [RQ9] [RQ7]
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         pad_r <= adc_regs_pkg::PAD_OUT_DIR_RST;                  // [RQ8] [RQ10]
      else if (req.wr && req.addr == adc_regs_pkg::PAD_OUT_DIR_ADDR)
         pad_r <= req.wdata & adc_regs_pkg::PAD_OUT_DIR_MASK;     // [RQ7]
   end

   // start bit is masked off on write and never stored: it always reads back zero;
   // busy in the last config register is live core state, never stored
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         for (int i = 0; i < 6; i++)
            cfg_r[i] <= CFG_RST[i];                               // [RQ8]
      end
      else if (wr_hit_cfg)
         cfg_r[cfg_idx] <= req.wdata & CFG_MASK[cfg_idx];         // [RQ15] [RQ7]
      else
         cfg_r[0][adc_regs_pkg::START_BIT] <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         start_r <= 1'b0;
      else
         start_r <= wr_hit_cfg && cfg_idx == 3'h0
                    && req.wdata[adc_regs_pkg::START_BIT];        // [RQ16]
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         mode_r <= adc_regs_pkg::MODE_RST;                        // [RQ8] [RQ17]
      else if (req.wr && req.addr == adc_regs_pkg::MODE_ADDR)
         mode_r <= req.wdata & adc_regs_pkg::MODE_MASK;           // [RQ15] [RQ7]
   end

   // result formatting: saturate wide raw sum, then force non-significant
   // bits. resolution follows 2*log2(osr)+log2(nelc), capped at 16.
   assign osr_sel  = cfg_r[0][adc_regs_pkg::OSR_LSB +: 3];
   assign nelc_sel = cfg_r[0][adc_regs_pkg::NELC_LSB +: 2];

   always_comb
   begin
      logic [5:0] n;
      n = 6'(2 * (3 + osr_sel)) + 6'(nelc_sel);
      if (n >= 6'(adc_regs_pkg::FULL_RES))
         res_bits = 5'(adc_regs_pkg::FULL_RES);
      else
         res_bits = n[4:0];
   end

   always_comb
   begin
      int drop;
      drop = adc_regs_pkg::FULL_RES - int'(res_bits);
      forced_one = 16'h0000;
      keep_mask  = 16'hffff;
      if (drop > 0)
      begin
         forced_one = 16'(16'h0001 << (drop - 1));                // [RQ3]
         keep_mask  = 16'(16'hffff << drop);
      end
   end

   always_comb
   begin
      logic signed [adc_regs_pkg::RAW_W-1:0] s;
      s = raw.value;
      if (s > $signed(adc_regs_pkg::RAW_W'(32767)))
         sat_code = adc_regs_pkg::CODE_MAX;                       // [RQ2]
      else if (s < $signed(-adc_regs_pkg::RAW_W'(32768)))
         sat_code = adc_regs_pkg::CODE_MIN;                       // [RQ2]
      else
         sat_code = s[15:0];                                      // [RQ1]
   end

   assign result_nxt = (sat_code & keep_mask) | forced_one;       // [RQ3]

   // both bytes live in one 16-bit register written in a single cycle
   always_ff @(posedge clk)
   begin
      if (srst)
         result_r <= adc_regs_pkg::RESULT_RST;
      else if (raw.valid)
         result_r <= result_nxt;                                  // [RQ18]
   end

   // pad inputs come from the pins: two flops before anything reads them
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         pad_meta_r <= 2'h0;
         pad_live_r <= 2'h0;
      end
      else
      begin
         pad_meta_r <= {pad1_in, pad0_in};
         pad_live_r <= pad_meta_r;                                // [RQ13]
      end
   end

   always_comb
   begin
      rdata_nxt = 8'h00;
      case (req.addr)
         adc_regs_pkg::OSC_CONTROL_ADDR: rdata_nxt = osc_r;
         adc_regs_pkg::PAD_OUT_DIR_ADDR: rdata_nxt = pad_r;
         adc_regs_pkg::PAD_IN_ADDR:      rdata_nxt = {6'h00, pad_live_r}; // [RQ13]
         adc_regs_pkg::RESULT_LOW_ADDR:  rdata_nxt = result_r[7:0];  // [RQ14]
         adc_regs_pkg::RESULT_HIGH_ADDR: rdata_nxt = result_r[15:8]; // [RQ14]
         adc_regs_pkg::CFG_A_ADDR:       rdata_nxt = cfg_r[0];
         adc_regs_pkg::CFG_B_ADDR:       rdata_nxt = cfg_r[1];
         adc_regs_pkg::CFG_C_ADDR:       rdata_nxt = cfg_r[2];
         adc_regs_pkg::CFG_D_ADDR:       rdata_nxt = cfg_r[3];
         adc_regs_pkg::CFG_E_ADDR:       rdata_nxt = cfg_r[4];
         adc_regs_pkg::CFG_F_ADDR:
            rdata_nxt = cfg_r[5] | {conv_busy, 7'h00};
         adc_regs_pkg::MODE_ADDR:        rdata_nxt = mode_r;
         default:                        rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         rdata_r <= 8'h00;
      else if (req.rd)
         rdata_r <= rdata_nxt;
      else
         rdata_r <= 8'h00;
   end

   assign rdata = rdata_r;
   assign conv_start = start_r;
   assign osc_enable = osc_r[adc_regs_pkg::OSC_EN_BIT];             // [RQ9]
   // bias codes pass straight to the analog; 10 is left to the host
   assign converter_bias_select =
      cfg_r[1][adc_regs_pkg::CONV_BIAS_LSB +: 2];                   // [RQ4]
   assign amplifier_bias_select =
      cfg_r[1][adc_regs_pkg::AMP_BIAS_LSB +: 2];                    // [RQ5]
   assign stage_enable = cfg_r[1][3:0];                             // [RQ6]
   assign reference_out_enable = mode_r[adc_regs_pkg::REF_OUT_BIT]; // [RQ17]
   assign ext_reference_in_enable =
      mode_r[adc_regs_pkg::EXT_REF_IN_BIT];                         // [RQ17]

   assign pad1_oe = pad_r[adc_regs_pkg::PAD1_DIR_BIT]
                    && !ext_reference_in_enable;                    // [RQ11]
   assign pad0_oe = pad_r[adc_regs_pkg::PAD0_DIR_BIT]
                    && !reference_out_enable;                       // [RQ12]
   assign pad1_out = pad_r[adc_regs_pkg::PAD1_VAL_BIT];
   assign pad0_out = pad_r[adc_regs_pkg::PAD0_VAL_BIT];

   // assertions
   chk_osc_reset: assert property (@(posedge clk)
      $fell(srst) |-> osc_enable)                                   // [RQ9]
      else $error("oscillator enable not one after reset");

   chk_osc_upper: assert property (@(posedge clk) disable iff (srst)
      osc_r[7:1] == 7'h00)                                          // [RQ9]
      else $error("oscillator register upper bits set");

   chk_pad1_gate: assert property (@(posedge clk) disable iff (srst)
      ext_reference_in_enable |-> !pad1_oe)                         // [RQ11]
      else $error("pad one driven while reference input on");

   chk_pad0_gate: assert property (@(posedge clk) disable iff (srst)
      pad0_oe |-> pad_r[4] && !mode_r[1])                           // [RQ12]
      else $error("pad zero driven wrongly");

   chk_start_pulse: assert property (@(posedge clk) disable iff (srst)
      (req.wr && req.addr == adc_regs_pkg::CFG_A_ADDR && req.wdata[7])
      |=> conv_start ##1 conv_start == $past(req.wr && req.wdata[7]
      && req.addr == adc_regs_pkg::CFG_A_ADDR))                     // [RQ16]
      else $error("start pulse missing or too long");

   chk_result_load: assert property (@(posedge clk) disable iff (srst)
      raw.valid |=> result_r == $past(result_nxt))                  // [RQ18]
      else $error("result not loaded as one word");

   chk_result_sat: assert property (@(posedge clk) disable iff (srst)
      raw.valid && !raw.value[17] && raw.value[16:15] != 2'b00
      && res_bits == 5'd16 |=> result_r == 16'h7fff)                // [RQ2]
      else $error("positive overflow not clamped");

   chk_forced_bits: assert property (@(posedge clk) disable iff (srst)
      raw.valid && res_bits < 5'd16
      |=> result_r[16 - $past(res_bits) - 1] == 1'b1)               // [RQ3]
      else $error("forced lsb pattern missing");

   chk_read_delay: assert property (@(posedge clk) disable iff (srst)
      req.rd && req.addr == adc_regs_pkg::MODE_ADDR
      && !(req.wr) |=> rdata == {2'b00, mode_r[5:0]})               // [RQ15]
      else $error("mode read data wrong");

   chk_unused_pad: assert property (@(posedge clk) disable iff (srst)
      pad_r[7:6] == 2'b00 && pad_r[3:2] == 2'b00)                   // [RQ7]
      else $error("unused pad register bits stored");

   chk_rdata_idle: assert property (@(posedge clk) // [RQ15]
      disable iff (srst) !$past(req.rd) |-> rdata == 8'h00)
      else $error("read data not zero outside a read");

   chk_start_only: assert property (@(posedge clk) // [RQ16]
      disable iff (srst)
      conv_start |-> $past(req.wr && req.wdata[adc_regs_pkg::START_BIT]
      && req.addr == adc_regs_pkg::CFG_A_ADDR))
      else $error("start pulse without a start write");

   chk_result_min: assert property (@(posedge clk) // [RQ2]
      disable iff (srst)
      raw.valid && raw.value[17] && raw.value[16:15] != 2'b11
      && res_bits == 5'd16 |=> result_r == adc_regs_pkg::CODE_MIN)
      else $error("negative overflow not clamped");

   chk_forced_zeros: assert property (@(posedge clk) // [RQ3]
      disable iff (srst)
      raw.valid && res_bits < 5'd16 |=> (result_r
      & ~(16'hffff << (16 - $past(res_bits))))
      == 16'(16'h0001 << (15 - $past(res_bits))))
      else $error("forced lsb pattern wrong");

   chk_result_hold: assert property (@(posedge clk) // [RQ18]
      disable iff (srst) !raw.valid |=> $stable(result_r))
      else $error("result changed without a new value");

   chk_pad_sync: assert property (@(posedge clk) // [RQ13]
      disable iff (srst) pad_live_r == $past(pad_meta_r))
      else $error("pad level skipped a sync stage");

   chk_ref_reset: assert property (@(posedge clk) // [RQ17]
      $fell(srst) |-> pad0_oe && pad1_oe
      && !reference_out_enable && !ext_reference_in_enable)
      else $error("pad functions not at defaults after reset");

   chk_osc_write: assert property (@(posedge clk) // [RQ9]
      disable iff (srst)
      req.wr && req.addr == adc_regs_pkg::OSC_CONTROL_ADDR
      |=> osc_enable == $past(req.wdata[adc_regs_pkg::OSC_EN_BIT]))
      else $error("oscillator enable did not follow write");

   chk_bias_write: assert property (@(posedge clk) // [RQ4] [RQ5]
      disable iff (srst)
      req.wr && req.addr == adc_regs_pkg::CFG_B_ADDR
      |=> {converter_bias_select, amplifier_bias_select, stage_enable}
      == $past(req.wdata))
      else $error("bias or stage selection did not follow write");

   chk_mode_write: assert property (@(posedge clk) // [RQ17]
      disable iff (srst)
      req.wr && req.addr == adc_regs_pkg::MODE_ADDR
      |=> {reference_out_enable, ext_reference_in_enable}
      == $past(req.wdata[1:0]))
      else $error("reference pad enables did not follow write");

   chk_pad_read: assert property (@(posedge clk) // [RQ13]
      disable iff (srst)
      req.rd && req.addr == adc_regs_pkg::PAD_IN_ADDR
      |=> rdata == {6'h00, $past(pad_live_r)})
      else $error("pad input read wrong");

   chk_high_read: assert property (@(posedge clk) // [RQ14]
      disable iff (srst)
      req.rd && req.addr == adc_regs_pkg::RESULT_HIGH_ADDR
      |=> rdata == $past(result_r[15:8]))
      else $error("result high byte read wrong");

   cov_start: cover property (@(posedge clk) conv_start);
   cov_pad0_ref: cover property (@(posedge clk)
      pad_r[4] && reference_out_enable);
   cov_clamp_neg: cover property (@(posedge clk)
      raw.valid && result_nxt == 16'h8000);
   cov_forced: cover property (@(posedge clk)
      raw.valid && res_bits < 5'd16);
   cov_pad1_ref: cover property (@(posedge clk)
      pad_r[5] && ext_reference_in_enable);

endmodule

`default_nettype wire

// ==== shared/adc_regs_pkg.sv ====
// register map, field positions, reset values and carrier types of the
// sensor acquisition register bank.
// assumes an 8-bit register port clocked by the single system clock.
package adc_regs_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   localparam logic [7:0] OSC_CONTROL_ADDR   = 8'h30;
   localparam logic [7:0] PAD_OUT_DIR_ADDR   = 8'h40;
   localparam logic [7:0] PAD_IN_ADDR        = 8'h41;
   localparam logic [7:0] RESULT_LOW_ADDR    = 8'h50;
   localparam logic [7:0] RESULT_HIGH_ADDR   = 8'h51;
   localparam logic [7:0] CFG_A_ADDR         = 8'h52;
   localparam logic [7:0] CFG_B_ADDR         = 8'h53;
   localparam logic [7:0] CFG_C_ADDR         = 8'h54;
   localparam logic [7:0] CFG_D_ADDR         = 8'h55;
   localparam logic [7:0] CFG_E_ADDR         = 8'h56;
   localparam logic [7:0] CFG_F_ADDR         = 8'h57;
   localparam logic [7:0] MODE_ADDR          = 8'h70;

   // writable bit masks; unused bits are never stored
   localparam logic [7:0] OSC_CONTROL_MASK   = 8'h01;
   localparam logic [7:0] PAD_OUT_DIR_MASK   = 8'h33;
   localparam logic [7:0] CFG_A_MASK         = 8'h7e;
   localparam logic [7:0] CFG_B_MASK         = 8'hff;
   localparam logic [7:0] CFG_C_MASK         = 8'hff;
   localparam logic [7:0] CFG_D_MASK         = 8'hff;
   localparam logic [7:0] CFG_E_MASK         = 8'h7f;
   localparam logic [7:0] CFG_F_MASK         = 8'h7f;
   localparam logic [7:0] MODE_MASK          = 8'h3f;

   localparam logic [7:0] OSC_CONTROL_RST    = 8'h01;
   localparam logic [7:0] PAD_OUT_DIR_RST    = 8'h30;
   localparam logic [7:0] CFG_A_RST          = 8'h28;
   localparam logic [7:0] CFG_B_RST          = 8'hf0;
   localparam logic [7:0] CFG_C_RST          = 8'h00;
   localparam logic [7:0] CFG_D_RST          = 8'h0c;
   localparam logic [7:0] CFG_E_RST          = 8'h00;
   localparam logic [7:0] CFG_F_RST          = 8'h00;
   localparam logic [7:0] MODE_RST           = 8'h04;
   localparam logic [15:0] RESULT_RST        = 16'h0000;

   localparam int OSC_EN_BIT                 = 0;
   localparam int PAD1_DIR_BIT               = 5;
   localparam int PAD0_DIR_BIT               = 4;
   localparam int PAD1_VAL_BIT               = 1;
   localparam int PAD0_VAL_BIT               = 0;
   localparam int START_BIT                  = 7;
   localparam int NELC_LSB                   = 5;
   localparam int OSR_LSB                    = 2;
   localparam int CONV_BIAS_LSB              = 6;
   localparam int AMP_BIAS_LSB               = 4;
   localparam int BUSY_BIT                   = 7;
   localparam int REF_OUT_BIT                = 1;
   localparam int EXT_REF_IN_BIT             = 0;

   localparam logic [1:0] BIAS_QUARTER       = 2'h0;
   localparam logic [1:0] BIAS_HALF          = 2'h1;
   localparam logic [1:0] BIAS_FULL          = 2'h3;

   localparam logic [15:0] CODE_MAX          = 16'h7fff;
   localparam logic [15:0] CODE_MIN          = 16'h8000;
   localparam int FULL_RES                   = 16;
   localparam int RAW_W                      = 18;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } reg_req_type;

   typedef struct packed {
      logic              valid;
      logic [RAW_W-1:0]  value;
   } raw_result_type;

endpackage

// ==== verification/conv_core_model.sv ====
// stand-in for the modulator core: busy for a while after each start pulse,
// then one raw sum with a one-cycle valid.
// assumes the bench picks the raw value before it starts a conversion.
`timescale 1ns/1ps
`default_nettype none
module conv_core_model
#(
   parameter int BUSY_CYCLES = 8
)
(
   input  wire logic                     clk,
   input  wire logic                     srst,
   input  wire logic                     conv_start,
   input  wire logic [17:0]              next_value,
   output logic                          conv_busy,
   output adc_regs_pkg::raw_result_type  raw
);
   int unsigned cnt_r;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cnt_r <= 0;
         conv_busy <= 1'b0;
         raw <= '0;
      end
      else
      begin
         raw.valid <= 1'b0;
         // off-pulse value is scrambled so a stale capture shows up
         raw.value <= ~next_value;
         if (conv_start)
         begin
            cnt_r <= BUSY_CYCLES;
            conv_busy <= 1'b1;
         end
         else if (cnt_r != 0)
         begin
            cnt_r <= cnt_r - 1;
            if (cnt_r == 1)
            begin
               conv_busy <= 1'b0;
               raw.valid <= 1'b1;
               raw.value <= next_value;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== verification/sensor_adc_register_bank_tb_top.sv ====
// self-checking bench of the sensor register bank.
// assumes the core stand-in model and a bench-made pad wire per pin.
`timescale 1ns/1ps
`default_nettype none
module sensor_adc_register_bank_tb_top;
   logic                         clk = 1'b0;
   logic                         srst = 1'b1;
   adc_regs_pkg::reg_req_type    req = '0;
   adc_regs_pkg::raw_result_type raw;
   logic [7:0]                   rdata;
   logic                         conv_busy, conv_start, osc_en;
   logic                         ref_out_en, ext_ref_en;
   logic [1:0]                   conv_bias, amp_bias;
   logic [1:0]                   ext_lvl = 2'h0;
   logic [3:0]                   stage_en;
   logic                         p0_out, p0_oe, p1_out, p1_oe;
   logic [17:0]                  next_value = 18'h0_0000;
   wire                          p0_in, p1_in;
   int                           num_errors = 0;
   int                           cmp_count = 0;
   int                           cycles = 0;

   // pad wire: the bank wins while it drives, else the outside level
   assign p0_in = p0_oe ? p0_out : ext_lvl[0];
   assign p1_in = p1_oe ? p1_out : ext_lvl[1];

   always #2.5 clk = ~clk;

   sensor_adc_register_bank dut
   (
      .clk(clk), .srst(srst), .req(req), .rdata(rdata), .raw(raw),
      .conv_busy(conv_busy), .conv_start(conv_start),
      .osc_enable(osc_en), .converter_bias_select(conv_bias),
      .amplifier_bias_select(amp_bias), .stage_enable(stage_en),
      .reference_out_enable(ref_out_en),
      .ext_reference_in_enable(ext_ref_en),
      .pad0_in(p0_in), .pad1_in(p1_in), .pad0_out(p0_out),
      .pad0_oe(p0_oe), .pad1_out(p1_out), .pad1_oe(p1_oe)
   );

   conv_core_model core
   (
      .clk(clk), .srst(srst), .conv_start(conv_start),
      .next_value(next_value), .conv_busy(conv_busy), .raw(raw)
   );

   task automatic end_of_test;
      $display("errors %0d comparisons %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk_reg(string what, logic [7:0] exp, logic [7:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_code(string what, logic [15:0] exp, logic [15:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr_reg(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req <= '0;
   endtask

   task automatic check_rd(logic [7:0] a, logic [7:0] exp);
      @(posedge clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req <= '0;
      #1;
      chk_reg($sformatf("register %h", a), exp, rdata);
   endtask

   function automatic logic [15:0] fmt(int osr, int nelc, logic [17:0] r);
      int v;
      int n;
      v = $signed(r);
      n = 2 * (3 + osr) + nelc;
      if (v > 32767) v = 32767;
      if (v < -32768) v = -32768;
      if (n < 16) v = (v & ~((1 << (16 - n)) - 1)) | (1 << (15 - n));
      return v[15:0];
   endfunction

   task automatic reset_values;
      logic [7:0] a [13] = '{8'h30, 8'h40, 8'h41, 8'h50, 8'h51, 8'h52,
         8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h70, 8'h31};
      logic [7:0] e [13] = '{adc_regs_pkg::OSC_CONTROL_RST,
         adc_regs_pkg::PAD_OUT_DIR_RST, 8'h00, 8'h00, 8'h00,
         adc_regs_pkg::CFG_A_RST, adc_regs_pkg::CFG_B_RST,
         adc_regs_pkg::CFG_C_RST, adc_regs_pkg::CFG_D_RST,
         adc_regs_pkg::CFG_E_RST, adc_regs_pkg::CFG_F_RST,
         adc_regs_pkg::MODE_RST, 8'h00};
      for (int i = 0; i < 13; i++)
         check_rd(a[i], e[i]);
      chk_reg("oscillator", 8'h01, {7'h00, osc_en});
      chk_reg("bias", 8'h0f, {4'h0, conv_bias, amp_bias});
      chk_reg("pad oe", 8'h03, {6'h00, p1_oe, p0_oe});
   endtask

   task automatic unused_bits;
      logic [7:0] a [10] = '{8'h30, 8'h40, 8'h53, 8'h54, 8'h55, 8'h56,
         8'h57, 8'h70, 8'h50, 8'h31};
      logic [7:0] m [10] = '{adc_regs_pkg::OSC_CONTROL_MASK,
         adc_regs_pkg::PAD_OUT_DIR_MASK, adc_regs_pkg::CFG_B_MASK,
         adc_regs_pkg::CFG_C_MASK, adc_regs_pkg::CFG_D_MASK,
         adc_regs_pkg::CFG_E_MASK, adc_regs_pkg::CFG_F_MASK,
         adc_regs_pkg::MODE_MASK, 8'h00, 8'h00};
      for (int i = 0; i < 10; i++)
      begin
         wr_reg(a[i], 8'hff);
         check_rd(a[i], m[i]);
         wr_reg(a[i], 8'h00);
         check_rd(a[i], 8'h00);
      end
      chk_reg("oscillator off", 8'h00, {7'h00, osc_en});
      wr_reg(8'h52, 8'h7f);
      check_rd(8'h52, 8'h7e);
      wr_reg(8'h52, adc_regs_pkg::CFG_A_RST);
      wr_reg(8'h30, 8'h01);
      wr_reg(8'h70, adc_regs_pkg::MODE_RST);
   endtask

   task automatic bias_codes;
      logic [1:0] c [3] = '{2'h0, 2'h1, 2'h3};
      for (int i = 0; i < 3; i++)
      begin
         wr_reg(8'h53, {c[i], c[(i + 1) % 3], 4'h5});
         #1;
         chk_reg("bias", {c[i], c[(i + 1) % 3], 4'h5},
            {conv_bias, amp_bias, stage_en});
      end
      wr_reg(8'h53, 8'hf0); // idle host parks every stage
      #1;
      chk_reg("stages", 8'h00, {4'h0, stage_en});
   endtask

   task automatic pad_paths;
      // drive value and direction, mode, outside level, oe, live level
      logic [7:0] o [5] = '{8'h33, 8'h33, 8'h33, 8'h03, 8'h31};
      logic [7:0] md [5] = '{8'h04, 8'h06, 8'h05, 8'h04, 8'h04};
      logic [1:0] x [5] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h0};
      logic [1:0] eo [5] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h3};
      logic [7:0] ei [5] = '{8'h03, 8'h02, 8'h01, 8'h02, 8'h01};
      for (int i = 0; i < 5; i++)
      begin
         wr_reg(8'h40, o[i]);
         wr_reg(8'h70, md[i]);
         ext_lvl <= x[i];
         repeat (3) @(posedge clk);
         chk_reg("pad oe", {6'h00, eo[i]},
            {6'h00, p1_oe, p0_oe});
         chk_reg("pad drive", {o[i][1:0], md[i][1:0]},
            {p1_out, p0_out, ref_out_en, ext_ref_en});
         check_rd(8'h41, ei[i]);
      end
   endtask

   task automatic conversions;
      int o [8] = '{4, 4, 4, 2, 3, 0, 4, 2};
      int n [8] = '{2, 2, 2, 2, 3, 2, 0, 2};
      logic [17:0] r [8] = '{18'h0_1234, 18'h0_8000, 18'h3_7fff,
         18'h3_ffff, 18'h0_0100, 18'h0_0a5c, 18'h0_7ffd, 18'h1_ffff};
      logic [7:0] lo;
      for (int i = 0; i < 8; i++)
      begin
         next_value <= r[i];
         wr_reg(8'h52, {1'b1, n[i][1:0], o[i][2:0], 2'b00});
         #1;
         chk_reg("start", 8'h01, {7'h00, conv_start});
         check_rd(8'h57, 8'h80);
         for (int k = 0; k < 40 && raw.valid !== 1'b1; k++)
            @(posedge clk);
         @(posedge clk);
         req <= '{addr: 8'h50, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
         @(posedge clk);
         req <= '{addr: 8'h51, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
         #1;
         lo = rdata;
         @(posedge clk);
         req <= '0;
         #1;
         chk_code("result", fmt(o[i], n[i], r[i]), {rdata, lo});
      end
   endtask

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         num_errors++;
         end_of_test();
      end
   end

   initial
   begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      reset_values();
      unused_bits();
      bias_codes();
      pad_paths();
      conversions();
      end_of_test();
   end
endmodule
`default_nettype wire
